// ===== design/att_auto_trigger.sv
// Auto-trigger source selection and analog pin input disable, AXI4-Lite slave.
// Assumes one clock, synchronous active-high reset, event flags synchronous
// to CORE_CLK, and a converter core that pulses CONV_DONE per conversion.
`timescale 1ns/10ps
`default_nettype none
`include "att_map.svh"

module att_auto_trigger
   import att_pkg::*;
#(
   parameter int NUM_PINS = 8
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic [`ATT_AXI_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [`ATT_AXI_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [7:1] EVENT_FLAGS,
   input wire logic CONV_DONE,
   input wire logic CONV_BUSY,
   output logic CONV_START,
   output logic CONV_ENABLE,
   input wire logic [NUM_PINS-1:0] PIN_RAW,
   output logic [NUM_PINS-1:0] PIN_BUF_DISABLE,
   output logic IRQ
);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic conv_en_ff;
   logic auto_en_ff;
   logic done_ff;
   logic [2:0] sel_ff;
   logic [NUM_PINS-1:0] pin_dis_ff;
   logic [2:0] irq_stat_ff;
   logic [2:0] irq_en_ff;
   logic trig_prev_ff;
   logic start_ff;
   logic [NUM_PINS-1:0] pin_in_ff;
   att_wr_e wr_st_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic rvalid_ff;
   logic [1:0] bresp_ff;

   // ------------------------------------------------------------
   // Write channel: both address and data taken together
   // ------------------------------------------------------------
   logic wr_go;
   logic [7:0] waddr;
   logic wr_hit;
   // Byte lanes below the word index are ignored
   assign waddr = S_AXI_AWADDR[`ATT_AXI_AW-1:`ATT_IDX_LO];
   // Slave waits for both so the two may arrive in either order
   assign wr_go = (wr_st_ff == ATT_W_IDLE) && S_AXI_AWVALID && S_AXI_WVALID;
   assign S_AXI_AWREADY = wr_go;
   assign S_AXI_WREADY = wr_go;
   assign S_AXI_BVALID = (wr_st_ff == ATT_W_RESP);
   assign S_AXI_BRESP = bresp_ff;
   assign wr_hit = (waddr == `ATT_OFS_CTRL_A) || (waddr == `ATT_OFS_CTRL_B) ||
                   (waddr == `ATT_OFS_PIN_DIS) || (waddr == `ATT_OFS_IRQ_EN) ||
                   (waddr == `ATT_OFS_IRQ_CLR) || (waddr == `ATT_OFS_IRQ_STAT) ||
                   (waddr == `ATT_OFS_PIN_IN);

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         wr_st_ff <= ATT_W_IDLE;
         bresp_ff <= `ATT_RESP_OKAY;
      end else begin
         case (wr_st_ff)
            ATT_W_IDLE: begin
               if (wr_go) begin
                  wr_st_ff <= ATT_W_RESP;
                  bresp_ff <= wr_hit ? `ATT_RESP_OKAY : `ATT_RESP_SLVERR;
               end
            end
            ATT_W_RESP: begin
               if (S_AXI_BREADY) begin
                  wr_st_ff <= ATT_W_IDLE;
               end
            end
            default: begin
               wr_st_ff <= ATT_W_IDLE;
            end
         endcase
      end
   end

   logic wr_b0;
   assign wr_b0 = wr_go && S_AXI_WSTRB[0];

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   logic conv_abort;
   assign conv_abort = conv_en_ff && CONV_BUSY && wr_b0 && (waddr == `ATT_OFS_CTRL_A) &&
                       !S_AXI_WDATA[`ATT_BIT_CONV_EN];

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         conv_en_ff <= 1'b0;
         auto_en_ff <= 1'b0;
      end else if (wr_b0 && waddr == `ATT_OFS_CTRL_A) begin
         conv_en_ff <= S_AXI_WDATA[`ATT_BIT_CONV_EN];
         auto_en_ff <= S_AXI_WDATA[`ATT_BIT_AUTO_EN];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         sel_ff <= 3'h0;
      end else if (wr_b0 && waddr == `ATT_OFS_CTRL_B) begin
         sel_ff <= S_AXI_WDATA[`ATT_SEL_HI:`ATT_SEL_LO];
      end
   end

   // Completion sets, write-one clears, set wins
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         done_ff <= 1'b0;
      end else if (CONV_DONE) begin
         done_ff <= 1'b1;
      end else if (wr_b0 && waddr == `ATT_OFS_CTRL_A && S_AXI_WDATA[`ATT_BIT_DONE]) begin
         done_ff <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         pin_dis_ff <= NUM_PINS'(`ATT_RST_PIN_DIS);
      end else if (wr_b0 && waddr == `ATT_OFS_PIN_DIS) begin
         pin_dis_ff <= S_AXI_WDATA[NUM_PINS-1:0];
      end
   end

   // ------------------------------------------------------------
   // Trigger selection and edge detection
   // ------------------------------------------------------------
   logic trig_sig;
   logic trig_edge;
   // Source decode; free running owns no event flag
   always_comb begin
      case (att_src_e'(sel_ff))
         ATT_SRC_FREE: trig_sig = 1'b0;
         default: trig_sig = EVENT_FLAGS[sel_ff];
      endcase
   end

   // Compare with the previous cycle's selected level
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         trig_prev_ff <= 1'b0;
      end else begin
         trig_prev_ff <= trig_sig;
      end
   end

   // Selector change alters trig_sig, seen as an edge here
   // Free running forces trig_sig low, so switching to it cannot rise
   assign trig_edge = trig_sig && !trig_prev_ff;

   // Start on rising edge; only when enabled
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         start_ff <= 1'b0;
      end else begin
         start_ff <= conv_en_ff && auto_en_ff && trig_edge;
      end
   end
   assign CONV_START = start_ff;
   assign CONV_ENABLE = conv_en_ff;

   // ------------------------------------------------------------
   // Pin input path
   // ------------------------------------------------------------
   // Buffer disable per pin
   assign PIN_BUF_DISABLE = pin_dis_ff;

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         pin_in_ff <= '0;
      end else begin
         pin_in_ff <= PIN_RAW & ~pin_dis_ff;
      end
   end

   // ------------------------------------------------------------
   // Interrupts: sticky status, enable, write-one clear
   // ------------------------------------------------------------
   logic [2:0] irq_set;
   logic [2:0] irq_clr;
   assign irq_set = {conv_abort, CONV_DONE, start_ff};
   assign irq_clr = (wr_b0 && waddr == `ATT_OFS_IRQ_CLR) ? S_AXI_WDATA[2:0] : 3'h0;

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         irq_stat_ff <= `ATT_RST_IRQ;
      end else begin
         // Set wins over a same-cycle clear
         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         irq_en_ff <= `ATT_RST_IRQ;
      end else if (wr_b0 && waddr == `ATT_OFS_IRQ_EN) begin
         irq_en_ff <= S_AXI_WDATA[2:0];
      end
   end
   assign IRQ = |(irq_stat_ff & irq_en_ff);

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   logic [31:0] rd_mux;
   logic rd_hit;
   logic [7:0] raddr;
   assign raddr = S_AXI_ARADDR[`ATT_AXI_AW-1:`ATT_IDX_LO];
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (raddr)
         `ATT_OFS_CTRL_A: begin
            rd_mux[`ATT_BIT_CONV_EN] = conv_en_ff;
            rd_mux[`ATT_BIT_AUTO_EN] = auto_en_ff;
            rd_mux[`ATT_BIT_DONE] = done_ff;
         end
         `ATT_OFS_CTRL_B: rd_mux[`ATT_SEL_HI:`ATT_SEL_LO] = sel_ff;
         `ATT_OFS_PIN_DIS: rd_mux[NUM_PINS-1:0] = pin_dis_ff;
         `ATT_OFS_IRQ_STAT: rd_mux[2:0] = irq_stat_ff;
         `ATT_OFS_IRQ_EN: rd_mux[2:0] = irq_en_ff;
         `ATT_OFS_IRQ_CLR: rd_mux = 32'h0000_0000;
         `ATT_OFS_PIN_IN: rd_mux[NUM_PINS-1:0] = pin_in_ff;
         default: rd_hit = 1'b0;
      endcase
   end

   assign S_AXI_ARREADY = !rvalid_ff;
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= `ATT_RESP_OKAY;
      end else if (!rvalid_ff && S_AXI_ARVALID) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_mux;
         rresp_ff <= rd_hit ? `ATT_RESP_OKAY : `ATT_RESP_SLVERR;
      end else if (rvalid_ff && S_AXI_RREADY) begin
         rvalid_ff <= 1'b0;
      end
   end
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA = rdata_ff;
   assign S_AXI_RRESP = rresp_ff;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   start_needs_auto_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      CONV_START |-> $past(auto_en_ff))
      else $error("start without auto-trigger enable");

   edge_starts_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (conv_en_ff && auto_en_ff && trig_sig && !trig_prev_ff) |=> CONV_START)
      else $error("rising edge did not start conversion");

   switch_edge_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      ($changed(sel_ff) && !$past(trig_sig) && trig_sig && conv_en_ff && auto_en_ff) |=> CONV_START)
      else $error("source switch edge missed");

   start_needs_en_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      CONV_START |-> $past(conv_en_ff))
      else $error("start while converter disabled");

   free_no_start_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (sel_ff == 3'h0) |=> !CONV_START)
      else $error("free running created a trigger");

   pin_buf_off_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (wr_b0 && waddr == `ATT_OFS_PIN_DIS) |=> (PIN_BUF_DISABLE == $past(S_AXI_WDATA[NUM_PINS-1:0])))
      else $error("pin disable write not applied");

   pin_read_zero_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      ##1 ((pin_in_ff & $past(pin_dis_ff)) == '0))
      else $error("disabled pin read nonzero");

   done_set_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      CONV_DONE |=> done_ff)
      else $error("done flag not set");

   one_start_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      CONV_START |=> !CONV_START)
      else $error("one edge gave two starts");

   abort_off_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      conv_abort |=> !CONV_ENABLE)
      else $error("converter not switched off");

endmodule : att_auto_trigger
`default_nettype wire

// ===== design/att_map.svh
// Register map, field positions and reset values of the auto-trigger block.
// Offsets are word indices; the bus byte address is four times the index.
// Included by the top module; definitions only.
`ifndef ATT_MAP_SVH
`define ATT_MAP_SVH

`define ATT_OFS_CTRL_A      8'h7A
`define ATT_OFS_CTRL_B      8'h7B
`define ATT_OFS_PIN_DIS     8'h7E
`define ATT_OFS_IRQ_STAT    8'h80
`define ATT_OFS_IRQ_EN      8'h84
`define ATT_OFS_IRQ_CLR     8'h88
`define ATT_OFS_PIN_IN      8'h8C

`define ATT_AXI_AW          10
`define ATT_IDX_LO          2

`define ATT_BIT_CONV_EN     7
`define ATT_BIT_AUTO_EN     5
`define ATT_BIT_DONE        4
`define ATT_SEL_HI          2
`define ATT_SEL_LO          0

`define ATT_IRQ_START       0
`define ATT_IRQ_DONE        1
`define ATT_IRQ_ABORT       2

`define ATT_RST_CTRL        8'h00
`define ATT_RST_PIN_DIS     8'h00
`define ATT_RST_IRQ         3'h0

`define ATT_RESP_OKAY       2'h0
`define ATT_RESP_SLVERR     2'h2

`endif

// ===== design/att_pkg.sv
// Types of the auto-trigger block.
// Assumes att_map.svh is on the include path.
package att_pkg;
   typedef enum logic [2:0] {
      ATT_SRC_FREE = 3'h0,
      ATT_SRC_COMP = 3'h1,
      ATT_SRC_EXT0 = 3'h2,
      ATT_SRC_T0CA = 3'h3,
      ATT_SRC_T0OV = 3'h4,
      ATT_SRC_T1CB = 3'h5,
      ATT_SRC_T1OV = 3'h6,
      ATT_SRC_T1CP = 3'h7
   } att_src_e;

   typedef enum logic [2:0] {
      ATT_W_IDLE = 3'b001,
      ATT_W_RESP = 3'b010,
      ATT_W_SPARE = 3'b100
   } att_wr_e;
endpackage : att_pkg

// ===== sim/att_core_model.sv
// Behavioural converter core standing behind the auto-trigger block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module att_core_model #(
   parameter int LAT = 12
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic enable,
   output logic busy,
   output logic done
);
   int cnt_ff;

   // Dropping enable kills a running conversion, as the real core does
   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (rst || !enable) begin
         busy <= 1'b0;
         cnt_ff <= 0;
      end else if (start) begin
         busy <= 1'b1;
         cnt_ff <= LAT;
      end else if (busy) begin
         cnt_ff <= cnt_ff - 1;
         if (cnt_ff == 1) begin
            busy <= 1'b0;
            done <= 1'b1;
         end
      end
   end
endmodule : att_core_model

`default_nettype wire

// ===== sim/adc_auto_trigger_and_input_disable_bench.sv
// Self-checking bench of the auto-trigger and pin input disable block.
// Assumes the design package and att_core_model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module adc_auto_trigger_and_input_disable_bench;
   logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic conv_done, conv_busy, conv_start, conv_enable, irq;
   logic [9:0] awaddr, araddr;
   logic [7:0] pin_raw, pin_dis, d;
   logic [31:0] wdata, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [7:1] flags, f;
   int fails, n_tests, n_start, s, s0;
   integer seed;

   att_auto_trigger dut (
      .CORE_CLK(clk), .RST(rst),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .EVENT_FLAGS(flags), .CONV_DONE(conv_done), .CONV_BUSY(conv_busy),
      .CONV_START(conv_start), .CONV_ENABLE(conv_enable),
      .PIN_RAW(pin_raw), .PIN_BUF_DISABLE(pin_dis), .IRQ(irq)
   );

   att_core_model core (
      .clk(clk), .rst(rst), .start(conv_start), .enable(conv_enable), .busy(conv_busy), .done(conv_done)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test();
   end

   always @(posedge clk) if (conv_start === 1'b1) n_start++;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [1:0] exp_resp(input logic [7:0] a);
      return (a inside {8'h7A, 8'h7B, 8'h7E, 8'h80, 8'h84, 8'h88, 8'h8C}) ? 2'h0 : 2'h2;
   endfunction : exp_resp

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] dv);
      @(posedge clk);
      // Register index times four is the byte address
      awaddr <= {a, 2'b00};
      wdata <= dv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge clk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      chk({30'h0, r}, {30'h0, exp_resp(a)});
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= {a, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
      chk({30'h0, r}, {30'h0, exp_resp(a)});
   endtask : rd

   // Count starts caused by a flag pattern over a short window
   task automatic go(input logic [7:1] fv, input int e);
      s0 = n_start;
      @(posedge clk);
      flags <= fv;
      repeat (6) @(posedge clk);
      chk(32'(n_start - s0), 32'(e));
   endtask : go

   task automatic starts_after(input int e);
      repeat (4) @(posedge clk);
      chk(32'(n_start - s0), 32'(e));
   endtask : starts_after

   task automatic stop_test();
      $display("tests=%0d fails=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 32'hc19e_b185;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 10'h000;
      araddr = 10'h000;
      wdata = 32'h0000_0000;
      wstrb = 4'hf;
      flags = 7'h00;
      pin_raw = 8'h00;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(8'h7E);
      chk(v, 32'h0000_0000);
      rd(8'h7A);
      chk(v, 32'h0000_0000);
      rd(8'h90);
      chk(v, 32'h0000_0000);
      wr(8'h91, 32'h0000_0001);
      repeat (4) begin
         d = 8'($random(seed));
         pin_raw <= 8'($random(seed));
         wr(8'h7E, {24'h0, d});
         rd(8'h7E);
         chk(v, {24'h0, d});
         chk({24'h0, pin_dis}, {24'h0, d});
         rd(8'h8C);
         chk(v, {24'h0, pin_raw & ~d});
      end
      wr(8'h84, 32'h0000_0007);
      wr(8'h7A, 32'h0000_00A0);
      for (s = 1; s < 8; s++) begin
         f = 7'($random(seed));
         f[s] = 1'b0;
         go(f, 0);
         wr(8'h7B, 32'(s));
         f[s] = 1'b1;
         go(f, 1);
      end
      chk({31'h0, irq}, 32'h0000_0001);
      repeat (16) @(posedge clk);
      rd(8'h7A);
      chk(v, 32'h0000_00B0);
      wr(8'h88, 32'h0000_0007);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(8'h7A, 32'h0000_00B0);
      rd(8'h7A);
      chk(v, 32'h0000_00A0);
      f = 7'h00;
      f[3] = 1'b1;
      go(f, 0);
      s0 = n_start;
      wr(8'h7B, 32'h0000_0003);
      starts_after(1);
      wr(8'h7A, 32'h0000_0020);
      wr(8'h7B, 32'h0000_0001);
      s0 = n_start;
      wr(8'h7B, 32'h0000_0003);
      starts_after(0);
      chk({31'h0, conv_enable}, 32'h0000_0000);
      wr(8'h7A, 32'h0000_0080);
      go(7'h00, 0);
      go(7'h7F, 0);
      go(7'h00, 0);
      wr(8'h7A, 32'h0000_00A0);
      wr(8'h7B, 32'h0000_0001);
      go(7'h01, 1);
      repeat (16) @(posedge clk);
      s0 = n_start;
      wr(8'h7B, 32'h0000_0000);
      starts_after(0);
      // Drop the older abort status so the next abort is seen on its own
      wr(8'h88, 32'h0000_0004);
      wr(8'h7B, 32'h0000_0001);
      // Flag 1 is still high, so this switch itself starts one conversion
      go(7'h00, 1);
      go(7'h01, 1);
      wr(8'h7A, 32'h0000_0000);
      rd(8'h80);
      chk({31'h0, v[2]}, 32'h0000_0001);
      chk({31'h0, conv_enable}, 32'h0000_0000);
      wr(8'h84, 32'h0000_0000);
      wr(8'h88, 32'h0000_0007);
      wr(8'h7A, 32'h0000_00A0);
      go(7'h00, 0);
      go(7'h01, 1);
      chk({31'h0, irq}, 32'h0000_0000);
      rd(8'h80);
      chk({31'h0, v[0]}, 32'h0000_0001);
      wr(8'h84, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(8'h88, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000);
      stop_test();
   end
endmodule : adc_auto_trigger_and_input_disable_bench

`default_nettype wire
